// [hw/lism_link_fsm.v]
// Exchange-level link initialisation and recovery state machine
`timescale 1ns/100ps
`include "lism_defines.vh"

// Priority inside one cycle: reset command, then errors, then token advances,
// then timeouts. A token on the last cycle of Started or Connecting therefore
// still advances instead of timing out.
// Limitation: the enable guard is watched only in Ready and Run; dropping it in
// Started or Connecting is left to those states' own timeouts.
// The timeout counts must fit CNT_W; the defaults fit in twelve bits.
// Pin edges only mark the first bit; decoding of tokens happens elsewhere.
module lism_link_fsm #(
  parameter integer CLK_NS    = `LISM_CLK_NS,
  parameter integer ERST_CYC  = (`LISM_T_ERST_NS + CLK_NS - 1) / CLK_NS,
  parameter integer EWAIT_CYC = (`LISM_T_EWAIT_NS + CLK_NS - 1) / CLK_NS,
  parameter integer TOUT_CYC  = `LISM_T_TOUT_NS / CLK_NS,
  parameter integer CNT_W     = `LISM_CNT_W
) (
  input  wire                   clk_i,
  input  wire                   srst_i,
  input  wire                   ce_i,
  input  wire                   link_enable_i,
  input  wire                   reset_cmd_i,
  input  wire                   data_pin_i,
  input  wire                   strobe_pin_i,
  input  wire                   got_null_i,
  input  wire                   got_fct_i,
  input  wire                   got_nchar_i,
  input  wire                   got_tcode_i,
  input  wire                   parity_err_i,
  input  wire                   escape_err_i,
  input  wire                   disc_err_i,
  input  wire                   credit_err_i,
  input  wire                   pkt_active_i,
  output reg  [`LISM_ST_W-1:0]  state_o,
  output reg                    rx_enable_o,
  output reg                    tx_enable_o,
  output reg                    tx_fct_ok_o,
  output reg                    run_o,
  output reg                    first_bit_o,
  output reg                    first_null_o,
  output reg                    null_tout_o,
  output reg                    fct_tout_o,
  output reg                    link_err_o,
  output reg                    eep_req_o
);

  // State codes
  localparam [`LISM_ST_W-1:0] S_ERST    = `LISM_S_ERST;
  localparam [`LISM_ST_W-1:0] S_EWAIT   = `LISM_S_EWAIT;
  localparam [`LISM_ST_W-1:0] S_READY   = `LISM_S_READY;
  localparam [`LISM_ST_W-1:0] S_STARTED = `LISM_S_STARTED;
  localparam [`LISM_ST_W-1:0] S_CONN    = `LISM_S_CONN;
  localparam [`LISM_ST_W-1:0] S_RUN     = `LISM_S_RUN;

  // Terminal counts, worked out wide and then cut to the counter width
  localparam integer     ERST_LAST_I  = ERST_CYC - 1;
  localparam integer     EWAIT_LAST_I = EWAIT_CYC - 1;
  localparam integer     TOUT_LAST_I  = TOUT_CYC - 1;
  localparam [CNT_W-1:0] ERST_LAST  = ERST_LAST_I[CNT_W-1:0];
  localparam [CNT_W-1:0] EWAIT_LAST = EWAIT_LAST_I[CNT_W-1:0];
  localparam [CNT_W-1:0] TOUT_LAST  = TOUT_LAST_I[CNT_W-1:0];
  localparam [CNT_W-1:0] CNT_ZERO   = {CNT_W{1'b0}};
  localparam [CNT_W-1:0] CNT_ONE    = {{(CNT_W-1){1'b0}}, 1'b1};

  // Pin front end sizes
  localparam integer     PIN_N    = `LISM_PIN_N;
  localparam integer     SYNC_N   = `LISM_SYNC_N;
  localparam integer     ARM_W    = `LISM_ARM_W;
  localparam [ARM_W-1:0] ARM_FULL = `LISM_ARM_FULL;
  localparam [ARM_W-1:0] ARM_ZERO = {ARM_W{1'b0}};
  localparam [ARM_W-1:0] ARM_ONE  = {{(ARM_W-1){1'b0}}, 1'b1};

  // State, timer and receive history
  reg  [`LISM_ST_W-1:0] state_reg;
  reg  [`LISM_ST_W-1:0] state_next;
  reg  [CNT_W-1:0]      cnt_reg;
  reg  [CNT_W-1:0]      cnt_next;
  reg                   first_bit_reg;
  reg                   first_bit_next;
  reg                   first_null_reg;
  reg                   first_null_next;
  reg                   null_tout_next;
  reg                   fct_tout_next;
  reg                   link_err_next;

  // Pin synchronisers: stage one of each feeds only stage two
  wire [PIN_N-1:0]      pin_raw;
  wire [PIN_N-1:0]      pin_sync;
  wire [PIN_N-1:0]      pin_chg;
  reg  [PIN_N-1:0]      pin_last_reg;
  reg  [ARM_W-1:0]      arm_reg;
  wire [ARM_W-1:0]      arm_next;
  wire                  arm_full;
  wire                  pin_edge;

  wire                  early_err;
  wire                  conn_err;
  wire                  run_err;
  wire                  tmr_erst;
  wire                  tmr_ewait;
  wire                  tmr_tout;

  // Pins packed in a fixed order so one loop serves both
  assign pin_raw = {strobe_pin_i, data_pin_i};

  // Two flops per pin; a pin may change at any moment against clk_i
  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi = gi + 1) begin : g_pin
      reg [SYNC_N-1:0] sync_reg;
      always @(posedge clk_i) begin
        if (srst_i) begin
          sync_reg <= {SYNC_N{1'b0}};
        end else if (ce_i) begin
          sync_reg <= {sync_reg[SYNC_N-2:0], pin_raw[gi]};
        end
      end
      assign pin_sync[gi] = sync_reg[SYNC_N-1];
    end
  endgenerate

  // Previous settled level and an arming count: the stages leave reset at zero,
  // so the first settled levels after reset must not be taken for a bit
  always @(posedge clk_i) begin
    if (srst_i) begin
      pin_last_reg <= {PIN_N{1'b0}};
      arm_reg      <= ARM_ZERO;
    end else if (ce_i) begin
      pin_last_reg <= pin_sync;
      arm_reg      <= arm_next;
    end
  end

  // Arming saturates once the whole pipeline holds real pin samples
  assign arm_full = (arm_reg == ARM_FULL);
  assign arm_next = arm_full ? arm_reg : arm_reg + ARM_ONE;

  // Any settled transition on data or strobe means a bit has arrived
  assign pin_chg  = pin_sync ^ pin_last_reg;
  assign pin_edge = arm_full & (|pin_chg);

  // Qualified error exits of ErrorWait, Ready and Started
  assign early_err = (first_bit_reg & disc_err_i) |
                     (first_null_reg & (parity_err_i | escape_err_i |
                      got_fct_i | got_nchar_i | got_tcode_i));

  // Connecting needs no qualifier: a NULL was already seen
  assign conn_err = disc_err_i | parity_err_i | escape_err_i |
                    got_nchar_i | got_tcode_i;

  // Run adds credit errors and loss of the enable guard
  assign run_err = disc_err_i | parity_err_i | escape_err_i |
                   credit_err_i | ~link_enable_i;

  // Timer flags; the counter is zero on the first cycle in a state
  assign tmr_erst  = (cnt_reg == ERST_LAST);
  assign tmr_ewait = (cnt_reg == EWAIT_LAST);
  assign tmr_tout  = (cnt_reg == TOUT_LAST);

  // Next state; reset command outranks everything, errors outrank timers
  always @* begin
    state_next     = state_reg;
    null_tout_next = 1'b0;
    fct_tout_next  = 1'b0;
    link_err_next  = 1'b0;
    if (reset_cmd_i) begin
      state_next = S_ERST;
    end else begin
      case (state_reg)
        S_ERST: begin
          if (tmr_erst) begin
            state_next = S_EWAIT;
          end
        end
        S_EWAIT: begin
          if (early_err) begin
            state_next    = S_ERST;
            link_err_next = 1'b1;
          end else if (tmr_ewait) begin
            state_next = S_READY;
          end
        end
        S_READY: begin
          // Transmitter stays silent here, so an early disconnect just resets
          if (early_err) begin
            state_next    = S_ERST;
            link_err_next = 1'b1;
          end else if (link_enable_i) begin
            state_next = S_STARTED;
          end
        end
        S_STARTED: begin
          if (early_err) begin
            state_next    = S_ERST;
            link_err_next = 1'b1;
          end else if (got_null_i) begin
            state_next = S_CONN;
          end else if (tmr_tout) begin
            state_next     = S_ERST;
            null_tout_next = 1'b1;
          end
        end
        S_CONN: begin
          if (conn_err) begin
            state_next    = S_ERST;
            link_err_next = 1'b1;
          end else if (got_fct_i) begin
            state_next = S_RUN;
          end else if (tmr_tout) begin
            state_next    = S_ERST;
            fct_tout_next = 1'b1;
          end
        end
        S_RUN: begin
          if (run_err) begin
            state_next    = S_ERST;
            link_err_next = 1'b1;
          end
        end
        default: begin
          state_next = S_ERST;
        end
      endcase
    end
  end

  // Timer restarts whenever the state changes, so each state sees a fresh count
  always @* begin
    if (state_next != state_reg) begin
      cnt_next = CNT_ZERO;
    end else if (state_reg[`LISM_B_READY] | state_reg[`LISM_B_RUN]) begin
      // No timer in Ready or Run; holding zero keeps the count from wrapping
      cnt_next = CNT_ZERO;
    end else begin
      cnt_next = cnt_reg + CNT_ONE;
    end
  end

  // Receive history flags, wiped whenever the link is sent back to reset
  always @* begin
    first_bit_next  = first_bit_reg;
    first_null_next = first_null_reg;
    if (state_next[`LISM_B_ERST]) begin
      first_bit_next  = 1'b0;
      first_null_next = 1'b0;
    end else begin
      if (pin_edge | got_null_i) begin
        first_bit_next = 1'b1;
      end
      if (got_null_i) begin
        first_null_next = 1'b1;
      end
    end
  end

  // State, timer and flags; reset lands in ErrorReset
  always @(posedge clk_i) begin
    if (srst_i) begin
      state_reg      <= S_ERST;
      cnt_reg        <= CNT_ZERO;
      first_bit_reg  <= 1'b0;
      first_null_reg <= 1'b0;
    end else if (ce_i) begin
      state_reg      <= state_next;
      cnt_reg        <= cnt_next;
      first_bit_reg  <= first_bit_next;
      first_null_reg <= first_null_next;
    end
  end

  // Registered outputs follow the next state so they line up with state_o
  always @(posedge clk_i) begin
    if (srst_i) begin
      state_o      <= S_ERST;
      rx_enable_o  <= 1'b0;
      tx_enable_o  <= 1'b0;
      tx_fct_ok_o  <= 1'b0;
      run_o        <= 1'b0;
      first_bit_o  <= 1'b0;
      first_null_o <= 1'b0;
      null_tout_o  <= 1'b0;
      fct_tout_o   <= 1'b0;
      link_err_o   <= 1'b0;
      eep_req_o    <= 1'b0;
    end else if (ce_i) begin
      state_o      <= state_next;
      rx_enable_o  <= ~state_next[`LISM_B_ERST];
      // NULLs only go out once started; early states never drive the line
      tx_enable_o  <= state_next[`LISM_B_STARTED] | state_next[`LISM_B_CONN] |
                      state_next[`LISM_B_RUN];
      tx_fct_ok_o  <= state_next[`LISM_B_CONN] | state_next[`LISM_B_RUN];
      run_o        <= state_next[`LISM_B_RUN];
      first_bit_o  <= first_bit_next;
      first_null_o <= first_null_next;
      null_tout_o  <= null_tout_next;
      fct_tout_o   <= fct_tout_next;
      // Timeouts count as link errors, so the user watches one error strobe
      link_err_o   <= link_err_next | null_tout_next | fct_tout_next;
      // A packet cut by a link failure in Run must be closed with an error marker
      eep_req_o    <= state_reg[`LISM_B_RUN] & state_next[`LISM_B_ERST] &
                      pkt_active_i & ~reset_cmd_i;
    end
  end

endmodule // lism_link_fsm

// [hw/lism_defines.vh]
// Constants for the link initialisation state machine
`ifndef LISM_DEFINES_VH
`define LISM_DEFINES_VH
// Timing, in ns, and the local clock period
`define LISM_CLK_NS        10
`define LISM_T_ERST_NS     6400
`define LISM_T_EWAIT_NS    12800
`define LISM_T_TOUT_NS     12800
`define LISM_CNT_W         12
// Pin front end: two pins, two sync stages, arming count saturates at three
`define LISM_PIN_N         2
`define LISM_SYNC_N        2
`define LISM_ARM_W         2
`define LISM_ARM_FULL      2'h3
// One-hot state codes and their bit positions
`define LISM_ST_W          6
`define LISM_B_ERST        0
`define LISM_B_EWAIT       1
`define LISM_B_READY       2
`define LISM_B_STARTED     3
`define LISM_B_CONN        4
`define LISM_B_RUN         5
`define LISM_S_ERST        6'h01
`define LISM_S_EWAIT       6'h02
`define LISM_S_READY       6'h04
`define LISM_S_STARTED     6'h08
`define LISM_S_CONN        6'h10
`define LISM_S_RUN         6'h20
`endif

// [dv/lism_link_fsm_assertions.sv]
// Checker for the link initialisation state machine ports
`timescale 1ns/100ps
`include "lism_defines.vh"
module lism_link_fsm_chk #(
  parameter integer ERST_CYC  = 640,
  parameter integer EWAIT_CYC = 1280,
  parameter integer TOUT_CYC  = 1280
) (
  input wire       clk_i,
  input wire       srst_i,
  input wire       ce_i,
  input wire       link_enable_i,
  input wire       reset_cmd_i,
  input wire       got_null_i,
  input wire       got_fct_i,
  input wire       got_nchar_i,
  input wire       got_tcode_i,
  input wire       parity_err_i,
  input wire       escape_err_i,
  input wire       disc_err_i,
  input wire       credit_err_i,
  input wire       pkt_active_i,
  input wire [5:0] state_o,
  input wire       tx_enable_o,
  input wire       tx_fct_ok_o,
  input wire       run_o,
  input wire       first_bit_o,
  input wire       first_null_o,
  input wire       null_tout_o,
  input wire       fct_tout_o,
  input wire       link_err_o,
  input wire       eep_req_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // Cycles spent in the present state; starts at all ones so the first cycle reads zero
  reg  [5:0]  st_reg;
  reg  [12:0] cnt_reg;
  wire [12:0] cnt_w  = (state_o != st_reg) ? 13'h0000 : cnt_reg + 13'h0001;
  wire        e_conn = disc_err_i | parity_err_i | escape_err_i | got_nchar_i | got_tcode_i;
  wire        e_run  = disc_err_i | parity_err_i | escape_err_i | credit_err_i;
  wire        quiet  = !(reset_cmd_i | e_conn | got_fct_i);
  always @(posedge clk_i) begin
    if (srst_i) begin
      st_reg  <= `LISM_S_ERST;
      cnt_reg <= 13'h1fff;
    end else if (ce_i) begin
      st_reg  <= state_o;
      cnt_reg <= cnt_w;
    end
  end
  sequence s_null; state_o == `LISM_S_STARTED && ce_i && got_null_i && quiet; endsequence
  sequence s_conn;
    state_o == `LISM_S_CONN && tx_fct_ok_o && first_null_o && first_bit_o;
  endsequence
  property p_erst; state_o == `LISM_S_ERST && ce_i && !reset_cmd_i |=>
    state_o == (($past(cnt_w) == ERST_CYC - 1) ? `LISM_S_EWAIT : `LISM_S_ERST); endproperty
  a_erst: assert property (p_erst) else $error("ErrorReset dwell wrong");
  property p_ewait; state_o == `LISM_S_EWAIT && ce_i && quiet |=>
    state_o == (($past(cnt_w) == EWAIT_CYC - 1) ? `LISM_S_READY : `LISM_S_EWAIT); endproperty
  a_ewait: assert property (p_ewait) else $error("ErrorWait dwell wrong");
  property p_ready; state_o == `LISM_S_READY && ce_i && !link_enable_i |=>
    state_o != `LISM_S_STARTED; endproperty
  a_ready: assert property (p_ready) else $error("Started without enable");
  property p_ntout; state_o == `LISM_S_STARTED && ce_i && quiet && !got_null_i
    && cnt_w == TOUT_CYC - 1 |=> state_o == `LISM_S_ERST && null_tout_o; endproperty
  a_ntout: assert property (p_ntout) else $error("NULL timeout missed");
  property p_connect; s_null |=> s_conn; endproperty
  a_connect: assert property (p_connect) else $error("NULL did not connect");
  property p_ftout; state_o == `LISM_S_CONN && ce_i && quiet && cnt_w == TOUT_CYC - 1
    |=> state_o == `LISM_S_ERST && fct_tout_o; endproperty
  a_ftout: assert property (p_ftout) else $error("FCT timeout missed");
  property p_cerr; state_o == `LISM_S_CONN && ce_i && e_conn |=> state_o == `LISM_S_ERST;
  endproperty
  a_cerr: assert property (p_cerr) else $error("Connecting error ignored");
  property p_run; state_o == `LISM_S_CONN && ce_i && got_fct_i && !reset_cmd_i && !e_conn
    |=> state_o == `LISM_S_RUN && run_o; endproperty
  a_run: assert property (p_run) else $error("FCT did not reach Run");
  property p_rexit; state_o == `LISM_S_RUN && ce_i && (e_run || !link_enable_i)
    |=> state_o == `LISM_S_ERST && !tx_enable_o; endproperty
  a_rexit: assert property (p_rexit) else $error("Run exit missed");
  property p_eep; state_o == `LISM_S_RUN && ce_i && pkt_active_i && !reset_cmd_i
    && (e_run || !link_enable_i) |=> eep_req_o; endproperty
  a_eep: assert property (p_eep) else $error("Cut packet not marked");
  property p_cmd; ce_i && reset_cmd_i |=> state_o == `LISM_S_ERST; endproperty
  a_cmd: assert property (p_cmd) else $error("Reset command ignored");
  property p_edisc; state_o[3:1] != 3'h0 && ce_i && first_bit_o && disc_err_i && !reset_cmd_i
    |=> state_o == `LISM_S_ERST && !tx_enable_o && link_err_o; endproperty
  a_edisc: assert property (p_edisc) else $error("Early disconnect ignored");
  property p_enull; state_o[3:1] != 3'h0 && ce_i && first_null_o && !reset_cmd_i &&
    (parity_err_i || escape_err_i || got_fct_i || got_nchar_i || got_tcode_i)
    |=> state_o == `LISM_S_ERST && link_err_o; endproperty
  a_enull: assert property (p_enull) else $error("Early qualified error ignored");
endmodule // lism_link_fsm_chk
bind lism_link_fsm lism_link_fsm_chk #(.ERST_CYC(ERST_CYC), .EWAIT_CYC(EWAIT_CYC),
  .TOUT_CYC(TOUT_CYC)) u_chk (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i),
  .link_enable_i(link_enable_i), .reset_cmd_i(reset_cmd_i), .got_null_i(got_null_i),
  .got_fct_i(got_fct_i), .got_nchar_i(got_nchar_i), .got_tcode_i(got_tcode_i),
  .parity_err_i(parity_err_i), .escape_err_i(escape_err_i), .disc_err_i(disc_err_i),
  .credit_err_i(credit_err_i), .pkt_active_i(pkt_active_i), .state_o(state_o),
  .tx_enable_o(tx_enable_o), .tx_fct_ok_o(tx_fct_ok_o), .run_o(run_o),
  .first_bit_o(first_bit_o), .first_null_o(first_null_o), .null_tout_o(null_tout_o),
  .fct_tout_o(fct_tout_o), .link_err_o(link_err_o), .eep_req_o(eep_req_o));

// [dv/lism_peer.sv]
// Far-end link model: sends a token frame on data-strobe, then flags it locally
`timescale 1ns/100ps
module lism_peer (
  input  wire clk_i,
  input  wire null_req_i,
  input  wire fct_req_i,
  output reg  data_o,
  output reg  strobe_o,
  output reg  got_null_o,
  output reg  got_fct_o
);
  integer i;
  reg     kind;
  initial {data_o, strobe_o, got_null_o, got_fct_o} = 4'h0;
  // Link clock runs only within a frame; exactly one line moves per bit
  always begin
    @(posedge clk_i);
    if (null_req_i || fct_req_i) begin
      kind = fct_req_i;
      // Start off the clock edge so no pin change lands on a sampling edge
      #3;
      for (i = 0; i < 8; i = i + 1) begin
        #80;
        if (i[0] != data_o) data_o = i[0];
        else strobe_o = ~strobe_o;
      end
      @(posedge clk_i);
      got_null_o <= !kind;
      got_fct_o  <= kind;
      @(posedge clk_i);
      got_null_o <= 1'b0;
      got_fct_o  <= 1'b0;
    end
  end
endmodule // lism_peer

// [dv/testbench.sv]
// Self-checking bench for the link initialisation state machine
`timescale 1ns/100ps
`include "lism_defines.vh"
`define CHK(a, b, m) begin tests_run++; if ((a) !== (b)) begin fails++; \
  $display("MISMATCH t=%0t %s", $time, m); end end
module testbench;
  localparam integer EC = 8, WC = 16, TC = 200;
  reg clk_i = 0, srst_i = 1, ce_i = 1, en = 0, pkt = 0, nreq = 0, freq = 0;
  reg [6:0] ev = 7'h00; // cmd credit disc escape parity tcode nchar
  wire dp, sp, gn, gf, rxe, txe, fok, run, fb, fn, nto, fto, lerr, eep;
  wire [5:0] st;
  integer fails = 0, tests_run = 0, c, n, i;
  lism_peer u_peer (.clk_i(clk_i), .null_req_i(nreq), .fct_req_i(freq), .data_o(dp),
    .strobe_o(sp), .got_null_o(gn), .got_fct_o(gf));
  lism_link_fsm #(.ERST_CYC(EC), .EWAIT_CYC(WC), .TOUT_CYC(TC)) DUT (.clk_i(clk_i),
    .srst_i(srst_i), .ce_i(ce_i), .link_enable_i(en), .reset_cmd_i(ev[6]),
    .data_pin_i(dp), .strobe_pin_i(sp), .got_null_i(gn), .got_fct_i(gf),
    .got_nchar_i(ev[0]), .got_tcode_i(ev[1]), .parity_err_i(ev[2]), .escape_err_i(ev[3]),
    .disc_err_i(ev[4]), .credit_err_i(ev[5]), .pkt_active_i(pkt), .state_o(st),
    .rx_enable_o(rxe), .tx_enable_o(txe), .tx_fct_ok_o(fok), .run_o(run), .first_bit_o(fb),
    .first_null_o(fn), .null_tout_o(nto), .fct_tout_o(fto), .link_err_o(lerr),
    .eep_req_o(eep));
  initial forever #5 clk_i = ~clk_i;
  task results; begin
    $display("Counts: tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  end endtask
  // Bounded wait; c ends as the number of edges taken to reach the state
  task wst(input [5:0] s); begin
    c = 0;
    while (st !== s && c < 3000) begin @(posedge clk_i); #1; c++; end
    if (st !== s) begin fails++; $display("MISMATCH t=%0t wait limit", $time); end
  end endtask
  task peer(input k); begin
    @(posedge clk_i) begin nreq <= !k; freq <= k; end
    @(posedge clk_i) begin nreq <= 1'b0; freq <= 1'b0; end
    for (n = 0; n < 100 && !(gn | gf); n++) @(posedge clk_i);
    if ((gn | gf) !== 1'b1) begin fails++; $display("MISMATCH t=%0t peer silent", $time); end
    #1;
  end endtask
  task kick(input [6:0] e); begin
    @(posedge clk_i) ev <= e;
    @(posedge clk_i) ev <= 7'h00;
    #1;
  end endtask
  // Reset, then climb: 0 Ready, 1 Started, 2 Connecting, 3 Run
  task go(input integer k); begin
    @(posedge clk_i) begin srst_i <= 1'b1; en <= 1'b0; pkt <= 1'b0; end
    repeat (6) @(posedge clk_i);
    srst_i <= 1'b0;
    wst(`LISM_S_EWAIT);
    wst(`LISM_S_READY);
    `CHK(c, WC, "ErrorWait dwell")
    if (k > 0) begin @(posedge clk_i) en <= 1'b1; wst(`LISM_S_STARTED); end
    if (k > 0) `CHK(txe, 1'b1, "no NULL send")
    if (k > 1) begin peer(0); `CHK(st, `LISM_S_CONN, "not Connecting") end
    if (k > 1) `CHK(fok, 1'b1, "FCT send not allowed")
    if (k > 1) `CHK(fn, 1'b1, "first NULL missed")
    if (k > 2) begin peer(1); `CHK(run, 1'b1, "not Run") end
  end endtask
  task t_early; begin
    go(0);
    peer(1);
    `CHK(st, `LISM_S_READY, "early FCT taken")
    `CHK(fb, 1'b1, "first bit missed")
    `CHK(rxe, 1'b1, "receiver off in Ready")
    kick(7'h10);
    `CHK(st, `LISM_S_ERST, "early disconnect")
    `CHK(txe, 1'b0, "sent before reset")
    `CHK(lerr, 1'b1, "disconnect not flagged")
    `CHK(rxe, 1'b0, "receiver left on")
    // A NULL in Ready arms the other early errors without moving the state
    go(0);
    peer(0);
    `CHK(st, `LISM_S_READY, "NULL in Ready moved")
    `CHK(fn, 1'b1, "first NULL missed")
    kick(7'h04);
    `CHK(st, `LISM_S_ERST, "qualified parity ignored")
    $display("t_early done");
  end endtask
  task t_tout; begin
    // Ten frozen edges stretch the timeout; eleven edges pass before the wait
    go(1);
    @(posedge clk_i) ce_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    ce_i <= 1'b1;
    #1;
    `CHK(st, `LISM_S_STARTED, "moved while frozen")
    wst(`LISM_S_ERST);
    `CHK(c, TC - 1, "NULL timeout time")
    `CHK(nto, 1'b1, "NULL timeout flag")
    go(2); wst(`LISM_S_ERST);
    `CHK(c, TC, "FCT timeout time")
    `CHK(fto, 1'b1, "FCT timeout flag")
    $display("t_tout done");
  end endtask
  task t_errs; begin
    // Credit errors count only in Run, so Connecting must ignore the last one
    for (i = 0; i < 6; i++) begin
      go(2); kick(7'h01 << i);
      `CHK(st, (i < 5) ? `LISM_S_ERST : `LISM_S_CONN, "Connecting error")
      if (i > 1) begin
        go(3); @(posedge clk_i) pkt <= 1'b1; kick(7'h01 << i);
        `CHK(st, `LISM_S_ERST, "Run error")
        `CHK(eep, 1'b1, "no error end marker")
      end
    end
    go(3); @(posedge clk_i) en <= 1'b0; @(posedge clk_i); #1;
    `CHK(st, `LISM_S_ERST, "disable in Run")
    go(2); kick(7'h40);
    `CHK(st, `LISM_S_ERST, "reset command")
    $display("t_errs done");
  end endtask
  // Tests take about 2,500 cycles; 10,000 cycles means something hangs
  initial begin #100000; fails++; results; end
  initial begin t_early; t_tout; t_errs; results; end
endmodule // testbench
